/* File: pkg/hpla_pkg.sv */
package hpla_pkg;

   // ************************************************************
   // Bus widths and channel count.
   // ************************************************************
   localparam int ADDR_W = 8;   // Host address bus width.
   localparam int DATA_W = 8;   // Host data bus width.
   localparam int NUM_CH = 6;   // Number of line channels.

   // ************************************************************
   // Register map and field layout.
   // ************************************************************
   localparam logic [7:0] CHCTL_BASE   = 8'h00;  // Channel control, one per channel.
   localparam logic [7:0] LOCK_STAT    = 8'h06;  // Live lock-lost levels, read only.
   localparam logic [7:0] INT_STAT     = 8'h07;  // Sticky lock events, write one to clear.
   localparam int         RATE_LSB     = 0;      // Line rate field, two bits.
   localparam int         INTEN_BIT    = 2;      // Interrupt enable bit.
   localparam logic [7:0] CHCTL_RESET  = 8'h00;  // Control value after reset.
   localparam logic [7:0] LOCK_RESET   = 8'h00;  // Lock flags after reset.

   // ************************************************************
   // Line rate codes in the channel control register.
   // ************************************************************
   typedef enum logic [1:0] {
      HPLA_RATE_E3   = 2'b00,
      HPLA_RATE_DS3  = 2'b01,
      HPLA_RATE_STS1 = 2'b10
   } hpla_rate_t;

   // ************************************************************
   // Timing constants.
   // ************************************************************
   localparam int ASYNC_DIV      = 4;     // Internal port clock is mclk divided by this.
   localparam int LOCK_WIN       = 1024;  // Reference edges in one lock window.
   localparam int LOCK_PERMILLE  = 5;     // Allowed deviation, 0.5 percent in tenths.
   localparam int LOCK_TOL       = LOCK_WIN * LOCK_PERMILLE / 1000;  // Edges of slack.

   // ************************************************************
   // Host bus request carrier.
   // ************************************************************
   typedef struct packed {
      logic              cs_n;   // Chip select, active low.
      logic              wr_n;   // Write strobe, active low.
      logic              rd_n;   // Read strobe, active low.
      logic [ADDR_W-1:0] addr;   // Register address.
      logic [DATA_W-1:0] wdata;  // Data bus value from the host.
   } hpla_host_req_t;

   // ************************************************************
   // Host port access states.
   // ************************************************************
   typedef enum logic [1:0] {
      HPLA_IDLE = 2'b00,
      HPLA_DONE = 2'b01
   } hpla_acc_t;

endpackage

/* File: hdl/hpla_top.sv */
`timescale 1ns/1ps
module hpla_top #(
   parameter int NUM_CH = hpla_pkg::NUM_CH
) (
   input  wire logic                           mclk,
   input  wire logic                           rst,
   input  wire hpla_pkg::hpla_host_req_t       host_req,
   input  wire logic                           pclk,
   input  wire logic                           host_sync_mode_strap,
   input  wire logic                           reg_reset_n,
   input  wire logic                           in_circuit_test_n,
   input  wire logic [NUM_CH-1:0]              rx_clk_recovered,
   input  wire logic                           ref_clock_e3_rate,
   input  wire logic                           ref_clock_ds3_rate,
   input  wire logic                           ref_clock_sts1_rate,
   output logic [hpla_pkg::DATA_W-1:0]         data_out,
   output logic                                data_oe_n,
   output logic                                rdy_out,
   output logic                                rdy_oe_n,
   output logic                                int_n_out,
   output logic                                int_oe_n,
   output logic [NUM_CH-1:0]                   rx_lock_lost_flag,
   output logic                                lock_oe_n
);

   // ************************************************************
   // Declarations.
   // ************************************************************
   localparam int CW = $clog2(hpla_pkg::LOCK_WIN) + 2;  // Lock counter width.
   localparam logic [CW-1:0] WIN_LAST = CW'(hpla_pkg::LOCK_WIN - 1);
   localparam logic [CW-1:0] REC_HI   = CW'(hpla_pkg::LOCK_WIN + hpla_pkg::LOCK_TOL);
   localparam logic [CW-1:0] REC_LO   = CW'(hpla_pkg::LOCK_WIN - hpla_pkg::LOCK_TOL);
   localparam logic [2:0] DIV_LAST = 3'(hpla_pkg::ASYNC_DIV - 1);

   logic [7:0]         chctl_reg [NUM_CH];  // Channel control registers.
   logic [NUM_CH-1:0]  lol_reg;             // Live lock lost condition per channel.
   logic [NUM_CH-1:0]  int_stat_reg;        // Sticky lock events.
   logic [NUM_CH-1:0]  rec_q_reg;           // Previous recovered clock samples.
   logic [2:0]         ref_q_reg;           // Previous reference clock samples.
   logic [2:0]         ref_rise;            // Reference clock rising edges.
   logic [NUM_CH-1:0]  rec_rise;            // Recovered clock rising edges.
   logic               pclk_q_reg;          // Previous processor clock sample.
   logic [2:0]         div_reg;             // Internal port clock divider.
   logic               port_tick;           // One port clock edge.
   hpla_pkg::hpla_acc_t acc_reg;            // Access state.
   logic               wr_go;               // Write taken this tick.
   logic               rd_go;               // Read taken this tick.
   logic [7:0]         rd_value;            // Addressed register contents.
   logic               irq_next;            // Interrupt request level.
   logic [NUM_CH-1:0]  lock_event;          // Rising lock lost condition per channel.

   assign ref_rise = {ref_clock_sts1_rate, ref_clock_ds3_rate, ref_clock_e3_rate} & ~ref_q_reg;
   assign rec_rise = rx_clk_recovered & ~rec_q_reg;

   // ************************************************************
   // Edge sampling of the clock-like inputs.
   // ************************************************************

   // Keeps one sample of each clock input to find its rising edges.
   always_ff @(posedge mclk) begin
      if (rst) begin
         ref_q_reg  <= 3'h0;
         rec_q_reg  <= '0;
         pclk_q_reg <= 1'b0;
      end else begin
         ref_q_reg  <= {ref_clock_sts1_rate, ref_clock_ds3_rate, ref_clock_e3_rate};
         rec_q_reg  <= rx_clk_recovered;
         pclk_q_reg <= pclk;
      end
   end

   // ************************************************************
   // Port timing source.
   // ************************************************************

   // Divides mclk to make the internal port clock used in async mode.
   always_ff @(posedge mclk) begin
      if (rst || div_reg == DIV_LAST) begin
         div_reg <= 3'h0;
      end else begin
         div_reg <= div_reg + 3'h1;
      end
   end

   // Strap high picks processor clock edges, strap low the divider.
   assign port_tick = host_sync_mode_strap ? (pclk & ~pclk_q_reg)
                                           : (div_reg == DIV_LAST);

   // ************************************************************
   // Host access sequencing.
   // ************************************************************

   // A strobe counts only with chip select low and only once per assertion.
   assign wr_go = port_tick && acc_reg == hpla_pkg::HPLA_IDLE && !host_req.cs_n
                  && !host_req.wr_n;
   assign rd_go = port_tick && acc_reg == hpla_pkg::HPLA_IDLE && !host_req.cs_n
                  && !host_req.rd_n && host_req.wr_n;

   // Moves to done after one access and back once the strobes drop.
   always_ff @(posedge mclk) begin
      if (rst) begin
         acc_reg <= hpla_pkg::HPLA_IDLE;
      end else begin
         case (acc_reg)
            hpla_pkg::HPLA_IDLE: begin
               if (wr_go || rd_go) begin
                  acc_reg <= hpla_pkg::HPLA_DONE;
               end
            end
            hpla_pkg::HPLA_DONE: begin
               // Release when both strobes are high or select drops.
               if (host_req.cs_n || (host_req.wr_n && host_req.rd_n)) begin
                  acc_reg <= hpla_pkg::HPLA_IDLE;
               end
            end
            default: begin
               acc_reg <= hpla_pkg::HPLA_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // Command registers.
   // ************************************************************

   // Channel control registers: written by the host, cleared by either reset.
   always_ff @(posedge mclk) begin
      for (int i = 0; i < NUM_CH; i++) begin
         if (rst || !reg_reset_n) begin
            chctl_reg[i] <= hpla_pkg::CHCTL_RESET;
         end else if (wr_go && host_req.addr == hpla_pkg::CHCTL_BASE + 8'(i)) begin
            chctl_reg[i] <= host_req.wdata;
         end
      end
   end

   // Sticky lock events; a new event wins over a write-one clear.
   always_ff @(posedge mclk) begin
      if (rst || !reg_reset_n) begin
         int_stat_reg <= '0;
      end else begin
         int_stat_reg <= (int_stat_reg
                          & ~((wr_go && host_req.addr == hpla_pkg::INT_STAT)
                              ? host_req.wdata[NUM_CH-1:0] : '0))
                         | lock_event;
      end
   end

   // Read multiplexer over the 256 locations; unused ones read zero.
   always_comb begin
      rd_value = 8'h00;
      if (host_req.addr < hpla_pkg::CHCTL_BASE + 8'(NUM_CH)) begin
         rd_value = chctl_reg[3'(host_req.addr - hpla_pkg::CHCTL_BASE)];
      end else if (host_req.addr == hpla_pkg::LOCK_STAT) begin
         rd_value = 8'(lol_reg);
      end else if (host_req.addr == hpla_pkg::INT_STAT) begin
         rd_value = 8'(int_stat_reg);
      end
   end

   // ************************************************************
   // Lock detection per channel.
   // ************************************************************

   for (genvar c = 0; c < NUM_CH; c++) begin : g_lock
      logic [CW-1:0] win_cnt_reg;  // Reference edges seen in this window.
      logic [CW-1:0] rec_cnt_reg;  // Recovered edges seen in this window.
      logic [CW-1:0] rec_total;    // Recovered edges including this cycle.
      logic          ref_edge;     // Edge of the reference for this rate.

      // Reference follows the channel's configured line rate.
      always_comb begin
         case (hpla_pkg::hpla_rate_t'(chctl_reg[c][hpla_pkg::RATE_LSB +: 2]))
            hpla_pkg::HPLA_RATE_DS3:  ref_edge = ref_rise[1];
            hpla_pkg::HPLA_RATE_STS1: ref_edge = ref_rise[2];
            default:                  ref_edge = ref_rise[0];
         endcase
      end

      assign rec_total = rec_cnt_reg + CW'(rec_rise[c]);
      assign lock_event[c] = ref_edge && win_cnt_reg == WIN_LAST && !lol_reg[c]
                             && (rec_total > REC_HI || rec_total < REC_LO);

      // Counts both clocks over a window and judges the deviation at its end.
      always_ff @(posedge mclk) begin
         if (rst || !reg_reset_n) begin
            win_cnt_reg <= '0;
            rec_cnt_reg <= '0;
            lol_reg[c]  <= 1'b0;
         end else if (ref_edge && win_cnt_reg == WIN_LAST) begin
            win_cnt_reg <= '0;
            rec_cnt_reg <= '0;
            lol_reg[c]  <= rec_total > REC_HI || rec_total < REC_LO;
         end else begin
            win_cnt_reg <= win_cnt_reg + CW'(ref_edge);
            // Saturate so a runaway recovered clock cannot wrap into range.
            if (rec_cnt_reg != '1) begin
               rec_cnt_reg <= rec_total;
            end
         end
      end
   end

   // ************************************************************
   // Pin drivers.
   // ************************************************************
   // Only events of channels with their interrupt enabled pull the pin.
   assign irq_next = |(int_stat_reg & int_en());

   // Returns the interrupt enable bit of every channel.
   function automatic logic [NUM_CH-1:0] int_en();
      logic [NUM_CH-1:0] en;
      en = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         en[i] = chctl_reg[i][hpla_pkg::INTEN_BIT];
      end
      return en;
   endfunction

   // Output levels, all registered.
   always_ff @(posedge mclk) begin
      if (rst) begin
         data_out          <= 8'h00;
         rdy_out           <= 1'b0;
         int_n_out         <= 1'b1;
         rx_lock_lost_flag <= '0;
      end else begin
         if (rd_go) begin
            data_out <= rd_value;
         end
         rdy_out           <= acc_reg == hpla_pkg::HPLA_DONE && !(wr_go || rd_go)
                              && !(host_req.cs_n || (host_req.wr_n && host_req.rd_n));
         int_n_out         <= !irq_next;
         rx_lock_lost_flag <= lol_reg;
      end
   end

   // Output enables, low while driving; the test pin floats everything.
   always_ff @(posedge mclk) begin
      if (rst) begin
         data_oe_n <= 1'b1;
         rdy_oe_n  <= 1'b1;
         int_oe_n  <= 1'b1;
         lock_oe_n <= 1'b1;
      end else begin
         data_oe_n <= !in_circuit_test_n || !(acc_reg == hpla_pkg::HPLA_DONE || rd_go)
                      || host_req.cs_n || host_req.rd_n || !host_req.wr_n;
         rdy_oe_n  <= !in_circuit_test_n;
         int_oe_n  <= !in_circuit_test_n;
         lock_oe_n <= !in_circuit_test_n;
      end
   end

endmodule

/* File: bench/hpla_chk.sv */
`timescale 1ns/1ps
// ************************************************************
// Port checker for the host port and lock alarm block.
// ************************************************************
module hpla_chk #(
   parameter int NUM_CH = 6
) (
   input wire logic                     mclk,
   input wire logic                     rst,
   input wire hpla_pkg::hpla_host_req_t host_req,
   input wire logic                     pclk,
   input wire logic                     host_sync_mode_strap,
   input wire logic                     reg_reset_n,
   input wire logic                     in_circuit_test_n,
   input wire logic                     data_oe_n,
   input wire logic                     rdy_out,
   input wire logic                     rdy_oe_n,
   input wire logic                     int_n_out,
   input wire logic                     int_oe_n,
   input wire logic [NUM_CH-1:0]        rx_lock_lost_flag,
   input wire logic                     lock_oe_n
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // Ready only ever answers a selected strobe taken two edges before.
   AST_RDY_CS: assert property ($rose(rdy_out) |-> !$past(host_req.cs_n, 2)
      && !($past(host_req.wr_n, 2) && $past(host_req.rd_n, 2)))
      else $error("ready rose without a selected strobe");
   // Ready stays up while the strobe is still held.
   AST_RDY_HOLD: assert property (rdy_out && !host_req.cs_n
      && !(host_req.wr_n && host_req.rd_n) |=> rdy_out)
      else $error("ready dropped while strobe held");
   // Ready falls soon after the strobes are released.
   AST_RDY_DROP: assert property (rdy_out && (host_req.cs_n
      || (host_req.wr_n && host_req.rd_n)) |-> ##[1:3] !rdy_out)
      else $error("ready not released after strobe");
   // The data bus is only driven after a selected read.
   AST_OE_READ: assert property ($fell(data_oe_n) |-> !$past(host_req.rd_n)
      && !$past(host_req.cs_n) && $past(host_req.wr_n))
      else $error("data bus driven without a read");
   // Read data is on the bus before ready is given.
   AST_RDY_DATA: assert property ($rose(rdy_out) && !$past(host_req.rd_n, 2)
      && $past(host_req.wr_n, 2) |-> !data_oe_n && !$past(data_oe_n))
      else $error("ready before read data");
   // In synchronous mode an access starts only on a processor clock rise.
   AST_SYNC_STEP: assert property ($rose(rdy_out) && $past(host_sync_mode_strap, 2)
      |-> $past(pclk, 2) && !$past(pclk, 3))
      else $error("sync access without processor clock rise");
   // Test pin low floats every output one edge later.
   AST_ICT_OFF: assert property (!in_circuit_test_n |=> data_oe_n
      && rdy_oe_n && int_oe_n && lock_oe_n)
      else $error("output driven in test mode");
   // Outside test mode the alarm outputs are driven.
   AST_OE_ON: assert property ($past(in_circuit_test_n) && !$past(rst)
      |-> !rdy_oe_n && !int_oe_n && !lock_oe_n)
      else $error("output floating in normal mode");
   // A held register reset clears the lock flags.
   AST_LOCK_CLR: assert property (!reg_reset_n [*4] |=> rx_lock_lost_flag == '0)
      else $error("lock flags survive register reset");
   // A held register reset releases the interrupt.
   AST_INT_CLR: assert property (!reg_reset_n [*4] |=> int_n_out)
      else $error("interrupt survives register reset");
   // Main scenarios reached.
   cover property ($rose(rdy_out) && host_sync_mode_strap);
   cover property ($fell(int_n_out));
   cover property ($rose(|rx_lock_lost_flag));
endmodule

/* File: bench/hpla_host.sv */
`timescale 1ns/1ps
// ************************************************************
// Host processor model on the parallel register port.
// ************************************************************
module hpla_host (
   input  wire logic               mclk,
   input  wire logic               rdy_out,
   input  wire logic               pclk_run,
   output hpla_pkg::hpla_host_req_t host_req,
   output logic                    pclk
);
   // Idle bus: deselected, strobes high, lines carrying a junk pattern.
   initial begin
      host_req = {3'b111, 16'hA55A};
      pclk = 1'b0;
   end
   // Processor clock of 25 MHz, still while not in sync mode.
   initial begin
      forever begin
         #20;
         pclk = pclk_run ? ~pclk : 1'b0;
      end
   end
   // One access: hold until ready is sampled, then release and wait.
   task automatic access(input logic sel_n, input logic wr, input logic [7:0] a,
                         input logic [7:0] d, output logic got);
      int n;
      @(posedge mclk);
      #1;
      host_req = {sel_n, !wr, wr, a, d};
      got = 1'b0;
      for (n = 0; n < 40 && !got; n++) begin
         @(posedge mclk);
         got = rdy_out;
      end
      #1;
      host_req = {3'b111, ~a, ~d};
      for (n = 0; n < 10 && rdy_out; n++) begin
         @(posedge mclk);
      end
      // Step off the edge so the caller's next change misses its time step.
      #1;
   endtask
endmodule

/* File: bench/tb_host_port_and_lock_alarm.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_host_port_and_lock_alarm;
   logic                     mclk, rst, pclk, pclk_run, host_sync_mode_strap;
   logic                     reg_reset_n, in_circuit_test_n, rdy_seen, got;
   logic                     ref_clock_e3_rate, ref_clock_ds3_rate, ref_clock_sts1_rate;
   logic [7:0]               data_out, v, exp_v;
   logic                     data_oe_n, rdy_out, rdy_oe_n, int_n_out, int_oe_n, lock_oe_n;
   logic [5:0]               rx_lock_lost_flag, rx_clk_recovered;
   logic [31:0]              seed;
   logic [7:0]               exp_q[$];
   int                       fail_count, checks_done;
   hpla_pkg::hpla_host_req_t host_req;
   // ************************************************************
   // Clock, line clocks and the two instances.
   // ************************************************************
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Reference clocks of 80, 100 and 60 ns, off the sampling edge.
   initial begin
      {ref_clock_e3_rate, ref_clock_ds3_rate, ref_clock_sts1_rate} = 3'b000;
      #1;
      fork
         forever #40 ref_clock_e3_rate = ~ref_clock_e3_rate;
         forever #50 ref_clock_ds3_rate = ~ref_clock_ds3_rate;
         forever #30 ref_clock_sts1_rate = ~ref_clock_sts1_rate;
      join
   end
   // Channel 0 runs at the E3 rate, the others at the DS3 rate.
   assign rx_clk_recovered = {{5{ref_clock_ds3_rate}}, ref_clock_e3_rate};
   hpla_top u_hpla_top (.mclk, .rst, .host_req, .pclk, .host_sync_mode_strap, .reg_reset_n,
      .in_circuit_test_n, .rx_clk_recovered, .ref_clock_e3_rate, .ref_clock_ds3_rate,
      .ref_clock_sts1_rate, .data_out, .data_oe_n, .rdy_out, .rdy_oe_n, .int_n_out,
      .int_oe_n, .rx_lock_lost_flag, .lock_oe_n);
   hpla_host u_hpla_host (.mclk, .rdy_out, .pclk_run, .host_req, .pclk);
   // ************************************************************
   // Helpers and the read monitor.
   // ************************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Every access must be answered; a missing answer ends the run.
   task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
      u_hpla_host.access(1'b0, wr, a, d, got);
      `CHK(got, 1'b1)
      if (got !== 1'b1) begin
         test_done();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      acc(1'b0, a, 8'h00);
   endtask
   // Compares read data with the oldest note as ready rises on a read.
   // Sampled on the falling edge, where the registered outputs have settled.
   always @(negedge mclk) begin
      if (rdy_out === 1'b1 && rdy_seen === 1'b0 && data_oe_n === 1'b0) begin
         exp_v = exp_q.pop_front();
         `CHK(data_out, exp_v)
      end
      rdy_seen = rdy_out;
   end
   // ************************************************************
   // Main sequence.
   // ************************************************************
   initial begin
      {rst, reg_reset_n, in_circuit_test_n} = 3'b111;
      // The factory test pin is no port of this block; the board grounds it.
      {host_sync_mode_strap, pclk_run, rdy_seen} = 3'b000;
      seed = 32'h94965495;
      step(8);
      rst = 1'b0;
      acc(1'b1, hpla_pkg::CHCTL_BASE + 8'h01, 8'h01);
      acc(1'b1, hpla_pkg::CHCTL_BASE + 8'h02, 8'h06);
      rd(hpla_pkg::CHCTL_BASE + 8'h01, 8'h01);
      seed = lfsr(seed);
      acc(1'b1, seed[7:0] | 8'h08, seed[15:8]);
      rd(seed[7:0] | 8'h08, 8'h00);
      u_hpla_host.access(1'b1, 1'b1, hpla_pkg::CHCTL_BASE, 8'h07, got);
      `CHK(got, 1'b0)
      rd(hpla_pkg::CHCTL_BASE, hpla_pkg::CHCTL_RESET);
      $display("register access test done");
      step(35000);
      `CHK(rx_lock_lost_flag, 6'h3C)
      `CHK(int_n_out, 1'b0)
      rd(hpla_pkg::LOCK_STAT, 8'h3C);
      acc(1'b1, hpla_pkg::INT_STAT, 8'hFF);
      step(3);
      `CHK(int_n_out, 1'b1)
      $display("lock alarm test done");
      {host_sync_mode_strap, pclk_run} = 2'b11;
      step(10);
      seed = lfsr(seed);
      v = seed[7:0] & 8'h07;
      acc(1'b1, hpla_pkg::CHCTL_BASE + 8'h04, v);
      rd(hpla_pkg::CHCTL_BASE + 8'h04, v);
      $display("sync mode test done");
      reg_reset_n = 1'b0;
      step(5);
      reg_reset_n = 1'b1;
      `CHK(rx_lock_lost_flag, 6'h00)
      rd(hpla_pkg::CHCTL_BASE + 8'h04, hpla_pkg::CHCTL_RESET);
      $display("register reset test done");
      in_circuit_test_n = 1'b0;
      step(2);
      `CHK({data_oe_n, rdy_oe_n, int_oe_n, lock_oe_n}, 4'hF)
      in_circuit_test_n = 1'b1;
      step(2);
      `CHK({data_oe_n, rdy_oe_n, int_oe_n, lock_oe_n}, 4'h8)
      `CHK(exp_q.size(), 0)
      $display("test mode test done");
      test_done();
   end
endmodule
bind hpla_top hpla_chk #(.NUM_CH(NUM_CH)) u_hpla_chk (.mclk, .rst, .host_req, .pclk,
   .host_sync_mode_strap, .reg_reset_n, .in_circuit_test_n, .data_oe_n, .rdy_out,
   .rdy_oe_n, .int_n_out, .int_oe_n, .rx_lock_lost_flag, .lock_oe_n);
